/* File: include/sbd_pkg.sv */
// Package for the sensor bus device register bank: offsets, fields, reset values.
// Assumes a register access port decoded by the link layer upstream.
package sbd_pkg;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [5:0] OFS_NODE_NUMBER = 6'h00;
    localparam logic [5:0] OFS_MAKER_CODE = 6'h01;
    localparam logic [5:0] OFS_PART_REV = 6'h02;
    localparam logic [5:0] OFS_CAPS = 6'h03;
    localparam logic [5:0] OFS_STATUS = 6'h04;
    localparam logic [5:0] OFS_CONTROL = 6'h05;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int STS_EVENT_POS = 0;
    localparam int STS_ERROR_POS = 4;
    localparam int STS_NACK_POS = 7;
    localparam int CTL_RESET_POS = 0;
    localparam int CTL_SHUTDOWN_POS = 1;
    localparam int CTL_REDUCED_POS = 2;
    localparam int CTL_ENABLE_POS = 4;

    // ****************************************
    // Reset and fixed values
    // ****************************************
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [15:0] CONTROL_RST = 16'h0000;
    localparam logic [15:0] CTL_WMASK = 16'h0017;
    localparam logic [15:0] CTL_BCAST_MASK = 16'h0003;
    localparam logic [15:0] CAPS_VALUE = 16'h0001;
    localparam logic [2:0] BCAST_NODE = 3'h0;
    localparam logic [2:0] NODE_BASE = 3'h1;
    localparam logic [3:0] RESET_CYCLES = 4'h8;

    typedef enum logic [1:0] {
        SBD_RUN = 2'b00,
        SBD_RESET = 2'b01,
        SBD_RESTART = 2'b11
    } sbd_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [2:0] node;
        logic [5:0] addr;
        logic [15:0] wdata;
    } sbd_req_t;

    typedef struct packed {
        logic shutdown;
        logic reduced;
        logic enable;
    } sbd_mode_t;

endpackage : sbd_pkg

/* File: design/sbd_regs.sv */
// Device-level register bank of a single-wire bus temperature sensor slave.
// Assumes the link layer hands over decoded register accesses one cycle each,
// with the node number still to be compared here, against the own node or, for control writes, the broadcast node.
`timescale 1ns/1ps
`default_nettype none

module sbd_regs
    import sbd_pkg::*;
#(
    parameter logic [15:0] MAKER_CODE = 16'hA5A5, // Arbitrary value
    parameter logic [10:0] PART_CODE = 11'h155, // Arbitrary value
    parameter logic [4:0] DIE_REVISION = 5'h01 // Arbitrary value
) (
    input wire logic sys_clk, // 125 MHz clock
    input wire logic reset_n, // Synchronous reset, active low
    input wire logic strap_pin_low, // Address strap bit 0
    input wire logic strap_pin_high, // Address strap bit 1
    input wire sbd_req_t req, // Register access request
    input wire logic result_read, // Master read the temperature result
    input wire logic function_event, // New result stored
    input wire logic function_error, // Result overrun
    input wire logic ack_error, // No-acknowledge seen in ack bit
    output logic [15:0] rdata, // Read data, registered
    output logic [2:0] node_number_field, // Own node number
    output logic device_reset, // Reset pulse to the rest of the device
    output logic device_ready, // Device operational
    output sbd_mode_t mode // Shutdown, low-power and enable
);

    // ****************************************
    // Decode helpers
    // ****************************************
    function automatic logic hit(input sbd_req_t r, input logic [5:0] ofs, input logic [2:0] own);
        hit = (r.addr == ofs) && (r.node == own);
    endfunction : hit

    sbd_state_t state_ff;
    logic [3:0] rst_cnt_ff;
    logic [2:0] node_ff;
    logic [7:0] status_ff;
    logic [15:0] control_ff;
    logic [15:0] rdata_ff;
    logic init_ff;
    logic soft_rst;
    logic in_reset;
    logic ctl_own_wr;
    logic ctl_bcast_wr;

    assign in_reset = (state_ff != SBD_RUN);
    assign ctl_own_wr = req.wr && hit(req, OFS_CONTROL, node_ff);
    assign ctl_bcast_wr = req.wr && hit(req, OFS_CONTROL, BCAST_NODE);
    assign soft_rst = (ctl_own_wr || ctl_bcast_wr) && req.wdata[CTL_RESET_POS];

    // ****************************************
    // Reset sequencer
    // ****************************************
    // Power-up enters the same sequence as a software reset, so no command is needed.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            state_ff <= SBD_RESET;
            rst_cnt_ff <= 4'h0;
        end else begin
            unique case (state_ff)
                SBD_RUN: begin
                    if (soft_rst) begin
                        state_ff <= SBD_RESET;
                        rst_cnt_ff <= 4'h0;
                    end
                end
                SBD_RESET: begin
                    rst_cnt_ff <= rst_cnt_ff + 4'h1;
                    if (rst_cnt_ff == RESET_CYCLES - 4'h1) begin
                        state_ff <= SBD_RESTART;
                    end
                end
                SBD_RESTART: begin
                    state_ff <= SBD_RUN;
                end
                default: begin
                    state_ff <= SBD_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            device_reset <= 1'b1;
            device_ready <= 1'b0;
        end else begin
            device_reset <= (state_ff == SBD_RESET) || (state_ff == SBD_RUN && soft_rst);
            device_ready <= (state_ff == SBD_RESTART) || (state_ff == SBD_RUN && !soft_rst);
        end
    end

    // ****************************************
    // Node number
    // ****************************************
    // Follows the straps each cycle; no write path exists.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            node_ff <= NODE_BASE;
        end else begin
            node_ff <= {1'b0, strap_pin_high, strap_pin_low} + NODE_BASE;
        end
    end

    assign node_number_field = node_ff;

    // ****************************************
    // Status flags
    // ****************************************
    // Set wins over a same-cycle clear, so no event is lost.
    logic sts_rd;
    assign sts_rd = req.rd && hit(req, OFS_STATUS, node_ff);

    always_ff @(posedge sys_clk) begin
        if (!reset_n || in_reset) begin
            status_ff <= STATUS_RST;
        end else begin
            if (function_event) begin
                status_ff[STS_EVENT_POS] <= 1'b1;
            end else if (result_read) begin
                status_ff[STS_EVENT_POS] <= 1'b0;
            end
            if (function_error) begin
                status_ff[STS_ERROR_POS] <= 1'b1;
            end else if (result_read) begin
                status_ff[STS_ERROR_POS] <= 1'b0;
            end
            if (ack_error) begin
                status_ff[STS_NACK_POS] <= 1'b1;
            end else if (sts_rd) begin
                status_ff[STS_NACK_POS] <= 1'b0;
            end
        end
    end

    // ****************************************
    // Control register
    // ****************************************
    // Reset bit stays high through the sequence and drops when it completes.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            control_ff <= CONTROL_RST;
        end else if (state_ff == SBD_RESTART) begin
            control_ff <= CONTROL_RST;
        end else if (in_reset) begin
            control_ff <= CONTROL_RST | (16'h0001 << CTL_RESET_POS);
        end else if (ctl_own_wr) begin
            control_ff <= req.wdata & CTL_WMASK;
        end else if (ctl_bcast_wr) begin
            control_ff <= (control_ff & ~CTL_BCAST_MASK) | (req.wdata & CTL_BCAST_MASK);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n || in_reset) begin
            mode <= '0;
        end else begin
            mode.shutdown <= control_ff[CTL_SHUTDOWN_POS];
            mode.reduced <= control_ff[CTL_REDUCED_POS];
            mode.enable <= control_ff[CTL_ENABLE_POS];
        end
    end

    // ****************************************
    // Read mux
    // ****************************************
    // Writes to read-only offsets fall through with no effect.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            rdata_ff <= 16'h0000;
        end else if (req.rd && req.node == node_ff) begin
            unique case (req.addr)
                OFS_NODE_NUMBER: rdata_ff <= {13'h0000, node_ff};
                OFS_MAKER_CODE: rdata_ff <= MAKER_CODE;
                OFS_PART_REV: rdata_ff <= {DIE_REVISION, PART_CODE};
                OFS_CAPS: rdata_ff <= CAPS_VALUE;
                OFS_STATUS: rdata_ff <= {8'h00, status_ff};
                OFS_CONTROL: rdata_ff <= control_ff;
                default: rdata_ff <= 16'h0000;
            endcase
        end
    end

    assign rdata = rdata_ff;

    // no write path exists for offsets 0 through 4.

endmodule : sbd_regs

`default_nettype wire

/* File: test/sbd_regs_sva.sv */
// Checker for the device register bank, bound to its top module.
// Assumes one-cycle register accesses and registered read data.
`timescale 1ns/1ps
`default_nettype none
module sbd_regs_sva
    import sbd_pkg::*;
(
    input wire logic sys_clk, // Clock
    input wire logic reset_n, // Sync reset, active low
    input wire logic strap_pin_low, // Strap bit 0
    input wire logic strap_pin_high, // Strap bit 1
    input wire sbd_req_t req, // Access request
    input wire logic result_read, // Result read
    input wire logic function_event, // Event pulse
    input wire logic function_error, // Error pulse
    input wire logic ack_error, // Nack pulse
    input wire logic [15:0] rdata, // Read data
    input wire logic [2:0] node_number_field, // Own node
    input wire logic device_reset, // Reset sequence
    input wire logic device_ready, // Running
    input wire sbd_mode_t mode // Mode copies
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    wire logic own = (req.node == node_number_field);
    sequence s_rd(logic [5:0] a);
        req.rd && own && req.addr == a;
    endsequence
    sequence s_ctl_wr;
        req.wr && own && req.addr == OFS_CONTROL && device_ready;
    endsequence
    a_node_track: assert property (1'b1 |=>
        node_number_field == $past(3'({strap_pin_high, strap_pin_low}) + 3'h1))
        else $error("node number off straps");
    a_sw_reset: assert property (s_ctl_wr ##0 req.wdata[0] |=> device_reset && !device_ready)
        else $error("reset bit did not start reset");
    a_reset_len: assert property ($rose(device_reset) |-> device_reset[*8] ##[1:4] device_ready)
        else $error("reset sequence length wrong");
    a_caps_fixed: assert property (s_rd(OFS_CAPS) |=> rdata == CAPS_VALUE)
        else $error("capabilities value wrong");
    a_status_rsvd: assert property (s_rd(OFS_STATUS) |=> rdata[6:5] == 2'h0 && rdata[3:1] == 3'h0)
        else $error("status reserved bits set");
    a_ctl_rsvd: assert property (s_rd(OFS_CONTROL) |=> (rdata & ~CTL_WMASK) == 16'h0000)
        else $error("control reserved bits set");
    a_mode_follow: assert property (s_ctl_wr ##0 !req.wdata[0] |-> ##2
        mode == $past({req.wdata[1], req.wdata[2], req.wdata[4]}, 2))
        else $error("mode not following control");
    // A broadcast reset legally clears every mode bit, so only plain broadcasts count here
    a_bcast_keep: assert property (req.wr && req.node == BCAST_NODE && req.addr == OFS_CONTROL
        && !req.wdata[0] && device_ready |-> ##2 mode[1:0] == $past(mode[1:0]))
        else $error("broadcast altered high bits");
    a_event_seen: assert property (function_event && !result_read ##1 !result_read
        ##1 s_rd(OFS_STATUS) ##0 !result_read && device_ready |=> rdata[0])
        else $error("event flag not set");
endmodule : sbd_regs_sva
bind sbd_regs sbd_regs_sva u_sva (.sys_clk, .reset_n, .strap_pin_low, .strap_pin_high, .req,
    .result_read, .function_event, .function_error, .ack_error, .rdata, .node_number_field,
    .device_reset, .device_ready, .mode);
`default_nettype wire

/* File: test/sbd_master_model.sv */
// Bus master model: issues one-cycle register accesses.
// Assumes the caller samples read data one cycle after the request.
`timescale 1ns/1ps
`default_nettype none
module sbd_master_model
    import sbd_pkg::*;
(
    input wire logic sys_clk, // Clock
    output sbd_req_t req // Access to the device
);
    // ****************************************
    // Access task
    // ****************************************
    initial req = '0;
    task automatic access(input logic w, input logic [2:0] n, input logic [5:0] a,
                          input logic [15:0] d);
        @(posedge sys_clk);
        req <= '{wr: w, rd: !w, node: n, addr: a, wdata: d};
        @(posedge sys_clk);
        req <= '0;
    endtask : access
endmodule : sbd_master_model
`default_nettype wire

/* File: test/test_sensor_bus_device_regs.sv */
// Self-checking bench for the device register bank.
// Assumes the master model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module test_sensor_bus_device_regs
    import sbd_pkg::*;
;
    // ****************************************
    // Set-up
    // ****************************************
    localparam logic [15:0] MK = 16'h3C5A; // Arbitrary value
    localparam logic [10:0] PC = 11'h2B7; // Arbitrary value
    localparam logic [4:0] RV = 5'h03; // Arbitrary value
    logic sys_clk = 1'b0, reset_n = 1'b0, strap_pin_low = 1'b0, strap_pin_high = 1'b1;
    logic result_read = 1'b0, function_event = 1'b0, function_error = 1'b0, ack_error = 1'b0;
    sbd_req_t req;
    logic [15:0] rdata;
    logic [2:0] node_number_field;
    logic device_reset, device_ready;
    sbd_mode_t mode;
    int fails = 0, tests_run = 0;
    logic [5:0] ra [7] = '{OFS_NODE_NUMBER, OFS_MAKER_CODE, OFS_PART_REV, OFS_CAPS, OFS_STATUS,
                           OFS_CONTROL, 6'h3F};
    logic [15:0] rv [7] = '{16'h0003, MK, {RV, PC}, 16'h0001, 16'h0000, 16'h0000, 16'h0000};
    sbd_regs #(.MAKER_CODE(MK), .PART_CODE(PC), .DIE_REVISION(RV)) dut (.sys_clk, .reset_n,
        .strap_pin_low, .strap_pin_high, .req, .result_read, .function_event, .function_error,
        .ack_error, .rdata, .node_number_field, .device_reset, .device_ready, .mode);
    sbd_master_model m (.sys_clk, .req);
    initial forever #4 sys_clk = ~sys_clk;
    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : test_done
    task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_data
    task automatic chk_bit(input logic got, input logic exp);
        chk_data({15'h0, got}, {15'h0, exp});
    endtask : chk_bit
    task automatic rd(input logic [2:0] n, input logic [5:0] a, input logic [15:0] e);
        m.access(1'b0, n, a, 16'h0000);
        #1;
        chk_data(rdata, e);
    endtask : rd
    task automatic pulse(input logic [3:0] p);
        @(posedge sys_clk);
        {result_read, function_event, function_error, ack_error} <= p;
        @(posedge sys_clk);
        {result_read, function_event, function_error, ack_error} <= 4'h0;
    endtask : pulse
    // Bounded wait: a hang ends the run as a mismatch
    task automatic wait_ready();
        for (int i = 0; i < 40 && device_ready !== 1'b1; i++) begin
            @(posedge sys_clk);
            #1;
        end
        if (device_ready !== 1'b1) begin
            fails++;
            test_done();
        end
    endtask : wait_ready
    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        wait_ready();
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 7; i++) rd(3'h3, ra[i], rv[i]);
            for (int i = 0; i < 5; i++) m.access(1'b1, 3'h3, ra[i], 16'hFFFF);
        end
        @(posedge sys_clk);
        strap_pin_low <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rd(3'h4, OFS_NODE_NUMBER, 16'h0004);
        chk_data({13'h0, node_number_field}, 16'h0004);
        pulse(4'b0111);
        rd(3'h4, OFS_STATUS, 16'h0091);
        rd(3'h4, OFS_STATUS, 16'h0011);
        pulse(4'b1000);
        rd(3'h4, OFS_STATUS, 16'h0000);
        m.access(1'b1, 3'h4, OFS_CONTROL, 16'hFFFE);
        #1;
        chk_bit(device_ready, 1'b1);
        rd(3'h4, OFS_CONTROL, 16'h0016);
        chk_data({13'h0, mode}, 16'h0007);
        m.access(1'b1, BCAST_NODE, OFS_CONTROL, 16'hFFF0);
        rd(3'h4, OFS_CONTROL, 16'h0014);
        chk_data({13'h0, mode}, 16'h0003);
        pulse(4'b0111);
        m.access(1'b1, 3'h4, OFS_CONTROL, 16'h0013);
        #1;
        chk_bit(device_reset, 1'b1);
        wait_ready();
        rd(3'h4, OFS_CONTROL, 16'h0000);
        rd(3'h4, OFS_STATUS, 16'h0000);
        chk_data({13'h0, mode}, 16'h0000);
        test_done();
    end
endmodule : test_sensor_bus_device_regs
`default_nettype wire
